//--- core/scio_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Mode 0: next, user1, user2, reset
// - Mode 1: next, user1, disable, reset
// - Mode 2: next, user1, user2, disable
// - Mode 3: input 4 is external test
// - Line 5 copy busy, 6 channel0 deadtime
// - Line 7 almost full, 8 full
// - Disable input inhibits counting while held
// - User bits latched at next leading edge
// - Key 0x68 write in test mode gives one test pulse
// - Test plus pulser gives a pulse every 40 ns
// - Test mode overrides front-panel counts, not disable
// - Bit 1 enables, bit 9 disables FIFO test
// - FIFO test writes 0x100-0x1FC push data
// - A24 block modifiers 0x3F, 0x3B accepted
// - A24 single modifiers 0x3D, 0x39 accepted
// - A16 modifiers 0x2D, 0x29 accepted
// - A32 block modifiers 0x0F, 0x0B accepted
// - A32 single modifiers 0x0D, 0x09 accepted
// - All LEDs but ready on in init, then ready+power
// - Paired set and clear control bits
module scio_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_q,
   // Bus address modifier qualification
   input wire logic [5:0] bus_am,
   input wire logic en_a16,
   input wire logic en_a24,
   input wire logic en_a32,
   output logic am_accept_q,
   output logic block_transfer_cycle_q,
   // Front-panel control inputs 1..4 (bit 0 is input 1)
   input wire logic [3:0] ctl_in,
   // Status sources from the rest of the scaler
   input wire logic copy_busy,
   input wire logic deadtime_en,
   input wire logic ch0_deadtimed,
   input wire logic fifo_almost_full,
   input wire logic fifo_full,
   // Control lines 5..8 (bit 0 is line 5)
   output logic [3:0] ctl_out_q,
   // Counting control towards the counters
   input wire logic [31:0] fp_count,
   output logic [31:0] count_pulse_q,
   output logic count_inhibit_q,
   output logic next_pulse_q,
   output logic [1:0] user_bits_q,
   output logic counter_reset_q,
   output logic ext_test_q,
   // LEDs (bit 0 ready, bit 1 power)
   output logic [7:0] led_q
);
   logic rst_s1_q, rst_n_q;
   logic [3:0] sync1_q, sync2_q, prev_q;
   logic [1:0] mode_q;
   logic test_q, pulser_q, ftest_q;
   logic [1:0] pdiv_q;
   logic key_pulse_q;
   logic [7:0] init_q;
   logic init_done_q;
   logic [31:0] fifo_mem [0:63];
   logic [5:0] wptr_q, rptr_q;
   logic [31:0] rd_d;
   logic am_ok;
   logic fp_ctl_sel, dis_d, rst_edge, next_edge, pulser_tick, fifo_wr;

   //----------------------------------------
   // Reset release
   //----------------------------------------
   // Reset asserts asynchronously but is released on the clock
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   //----------------------------------------
   // Front-panel input capture
   //----------------------------------------
   // Two flops against metastability, then a third for edge detection
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         prev_q <= 4'h0;
      end else begin
         sync1_q <= ctl_in;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // Decode of the input assignment per mode
   always_comb begin
      fp_ctl_sel = (mode_q != scio_pkg::SCIO_MODE_TEST);
      next_edge = fp_ctl_sel && sync2_q[0] && !prev_q[0];
      rst_edge = 1'b0;
      dis_d = 1'b0;
      case (scio_pkg::scio_mode_e'(mode_q))
         scio_pkg::SCIO_MODE_USER: rst_edge = sync2_q[3] && !prev_q[3];
         scio_pkg::SCIO_MODE_DIS3: begin
            dis_d = sync2_q[2];
            rst_edge = sync2_q[3] && !prev_q[3];
         end
         scio_pkg::SCIO_MODE_DIS4: dis_d = sync2_q[3];
         default: ;
      endcase
   end

   // Front-panel function outputs
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         next_pulse_q <= 1'b0;
         counter_reset_q <= 1'b0;
         count_inhibit_q <= 1'b0;
         ext_test_q <= 1'b0;
      end else begin
         next_pulse_q <= next_edge;
         counter_reset_q <= rst_edge;
         count_inhibit_q <= dis_d;
         ext_test_q <= (mode_q == scio_pkg::SCIO_MODE_TEST) && sync2_q[3];
      end
   end

   // User bits held from one next edge to the next; input 3 is not a user bit in mode 1
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         user_bits_q <= 2'b00;
      end else if (next_edge) begin
         user_bits_q[0] <= sync2_q[1];
         user_bits_q[1] <= (mode_q == scio_pkg::SCIO_MODE_DIS3) ? 1'b0 : sync2_q[2];
      end
   end

   //----------------------------------------
   // Status outputs on control lines 5..8
   //----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ctl_out_q <= 4'h0;
      end else begin
         ctl_out_q[0] <= copy_busy;
         ctl_out_q[1] <= deadtime_en && ch0_deadtimed;
         ctl_out_q[2] <= fifo_almost_full;
         ctl_out_q[3] <= fifo_full;
      end
   end

   //----------------------------------------
   // Control register
   //----------------------------------------
   // Set bits in the low byte, clear bits eight places up; clear wins if both are written
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mode_q <= 2'b00;
         test_q <= 1'b0;
         pulser_q <= 1'b0;
         ftest_q <= 1'b0;
      end else if (reg_wr && reg_addr == scio_pkg::CTRL_OFS) begin
         if (reg_wdata[scio_pkg::MODE0_BIT]) mode_q[0] <= 1'b1;
         if (reg_wdata[scio_pkg::MODE0_BIT + scio_pkg::CLR_SHIFT]) mode_q[0] <= 1'b0;
         if (reg_wdata[scio_pkg::MODE1_BIT]) mode_q[1] <= 1'b1;
         if (reg_wdata[scio_pkg::MODE1_BIT + scio_pkg::CLR_SHIFT]) mode_q[1] <= 1'b0;
         if (reg_wdata[scio_pkg::TEST_BIT]) test_q <= 1'b1;
         if (reg_wdata[scio_pkg::TEST_BIT + scio_pkg::CLR_SHIFT]) test_q <= 1'b0;
         if (reg_wdata[scio_pkg::PULSER_BIT]) pulser_q <= 1'b1;
         if (reg_wdata[scio_pkg::PULSER_BIT + scio_pkg::CLR_SHIFT]) pulser_q <= 1'b0;
         if (reg_wdata[scio_pkg::FTEST_BIT]) ftest_q <= 1'b1;
         if (reg_wdata[scio_pkg::FTEST_CLR_BIT]) ftest_q <= 1'b0;
      end
   end

   //----------------------------------------
   // Test pulse generation
   //----------------------------------------
   // Divide the 100 MHz clock down to a 25 MHz tick
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pdiv_q <= 2'b00;
      end else if (!pulser_q || pdiv_q == scio_pkg::PULSER_LAST) begin
         pdiv_q <= 2'b00;
      end else begin
         pdiv_q <= pdiv_q + 2'b01;
      end
   end
   assign pulser_tick = test_q && pulser_q && (pdiv_q == scio_pkg::PULSER_LAST);

   // Key write makes exactly one pulse when test mode is on
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         key_pulse_q <= 1'b0;
      end else begin
         key_pulse_q <= reg_wr && reg_addr == scio_pkg::KEY_PULSE_OFS && test_q;
      end
   end

   // Test pulses take priority; inhibit blocks both sources
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         count_pulse_q <= 32'h0000_0000;
      end else if (dis_d) begin
         count_pulse_q <= 32'h0000_0000;
      end else if (test_q) begin
         count_pulse_q <= {32{key_pulse_q || pulser_tick}};
      end else begin
         count_pulse_q <= fp_count;
      end
   end

   //----------------------------------------
   // FIFO test store
   //----------------------------------------
   assign fifo_wr = ftest_q && reg_wr && reg_addr >= scio_pkg::FIFO_LO_OFS &&
                    reg_addr <= scio_pkg::FIFO_HI_OFS && reg_addr[1:0] == 2'b00;
   // Small loop-back store; no full check, a write with 63 unread entries wraps wptr_q onto rptr_q and the store reads as empty
   always_ff @(posedge clk_sys) begin
      if (fifo_wr) fifo_mem[wptr_q] <= reg_wdata;
   end
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wptr_q <= 6'h00;
         rptr_q <= 6'h00;
      end else begin
         if (fifo_wr) wptr_q <= wptr_q + 6'h01;
         if (reg_rd && reg_addr == scio_pkg::FIFO_RD_OFS && rptr_q != wptr_q) rptr_q <= rptr_q + 6'h01;
      end
   end

   //----------------------------------------
   // Register read
   //----------------------------------------
   always_comb begin
      rd_d = 32'h0000_0000;
      if (reg_addr == scio_pkg::CTRL_OFS) begin
         rd_d[scio_pkg::FTEST_BIT] = ftest_q;
         rd_d[scio_pkg::MODE0_BIT] = mode_q[0];
         rd_d[scio_pkg::MODE1_BIT] = mode_q[1];
         rd_d[scio_pkg::TEST_BIT] = test_q;
         rd_d[scio_pkg::PULSER_BIT] = pulser_q;
      end else if (reg_addr == scio_pkg::STAT_OFS) begin
         rd_d[scio_pkg::STAT_LINES_LSB +: 4] = ctl_out_q;
         rd_d[scio_pkg::STAT_USER_LSB +: 2] = user_bits_q;
         rd_d[scio_pkg::STAT_INIT_BIT] = init_done_q;
      end else if (reg_addr == scio_pkg::FIFO_RD_OFS) begin
         rd_d = (rptr_q != wptr_q) ? fifo_mem[rptr_q] : 32'h0000_0000;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         reg_rdata_q <= 32'h0000_0000;
      end else begin
         reg_rdata_q <= reg_rd ? rd_d : 32'h0000_0000;
      end
   end

   //----------------------------------------
   // Address modifier check
   //----------------------------------------
   always_comb begin
      case (bus_am)
         scio_pkg::AM_A24_SUP_BLT, scio_pkg::AM_A24_NP_BLT: am_ok = en_a24;
         scio_pkg::AM_A24_SUP_DAT, scio_pkg::AM_A24_NP_DAT: am_ok = en_a24;
         scio_pkg::AM_A16_SUP, scio_pkg::AM_A16_NP: am_ok = en_a16;
         scio_pkg::AM_A32_SUP_BLT, scio_pkg::AM_A32_NP_BLT: am_ok = en_a32;
         scio_pkg::AM_A32_SUP_DAT, scio_pkg::AM_A32_NP_DAT: am_ok = en_a32;
         default: am_ok = 1'b0;
      endcase
   end
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         am_accept_q <= 1'b0;
         block_transfer_cycle_q <= 1'b0;
      end else begin
         am_accept_q <= am_ok;
         block_transfer_cycle_q <= am_ok && bus_am[1:0] == scio_pkg::AM_BLT_LOW;
      end
   end

   //----------------------------------------
   // Indicator sequencing
   //----------------------------------------
   // Fixed-length init phase stands in for self test
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         init_q <= 8'h00;
         init_done_q <= 1'b0;
         led_q <= 8'h00;
      end else begin
         if (!init_done_q) begin
            led_q <= scio_pkg::LED_ALL & ~scio_pkg::LED_READY;
            init_q <= init_q + 8'h01;
            if (init_q == scio_pkg::INIT_LAST) init_done_q <= 1'b1;
         end else begin
            led_q <= scio_pkg::LED_READY | scio_pkg::LED_POWER;
         end
      end
   end

   //----------------------------------------
   // Assertions
   //----------------------------------------
   sequence s_key_write;
      reg_wr && reg_addr == scio_pkg::KEY_PULSE_OFS && test_q && !dis_d;
   endsequence
   property p_key_pulse;
      @(posedge clk_sys) disable iff (!rst_n_q)
      s_key_write ##1 !dis_d |=> count_pulse_q == 32'hffff_ffff;
   endproperty
   a_key_pulse: assert property (p_key_pulse) else $error("key write gave no pulse");
   property p_inhibit;
      @(posedge clk_sys) disable iff (!rst_n_q)
      dis_d |=> count_pulse_q == 32'h0000_0000 && count_inhibit_q;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("counting while inhibited");
   property p_test_prio;
      @(posedge clk_sys) disable iff (!rst_n_q)
      test_q && !dis_d && !key_pulse_q && !pulser_tick |=> count_pulse_q == 32'h0000_0000;
   endproperty
   a_test_prio: assert property (p_test_prio) else $error("front panel leaked in test mode");
   property p_pulser;
      @(posedge clk_sys) disable iff (!rst_n_q)
      pulser_tick && test_q && pulser_q ##1 (test_q && pulser_q)[*4] |-> pulser_tick;
   endproperty
   a_pulser: assert property (p_pulser) else $error("pulser period wrong");
   property p_user;
      @(posedge clk_sys) disable iff (!rst_n_q)
      next_edge |=> user_bits_q[0] == $past(sync2_q[1]);
   endproperty
   a_user: assert property (p_user) else $error("user bit not latched");
   property p_lines;
      @(posedge clk_sys) disable iff (!rst_n_q)
      1'b1 |=> ctl_out_q[0] == $past(copy_busy) && ctl_out_q[3] == $past(fifo_full);
   endproperty
   a_lines: assert property (p_lines) else $error("status line wrong");
   property p_am;
      @(posedge clk_sys) disable iff (!rst_n_q)
      bus_am == scio_pkg::AM_A24_NP_DAT && en_a24 |=> am_accept_q;
   endproperty
   a_am: assert property (p_am) else $error("a24 access refused");
   property p_ftest_clr;
      @(posedge clk_sys) disable iff (!rst_n_q)
      reg_wr && reg_addr == scio_pkg::CTRL_OFS && reg_wdata[scio_pkg::FTEST_CLR_BIT] |=> !ftest_q;
   endproperty
   a_ftest_clr: assert property (p_ftest_clr) else $error("fifo test not cleared");
   property p_mode_rst;
      @(posedge clk_sys) disable iff (!rst_n_q)
      mode_q == scio_pkg::SCIO_MODE_USER && sync2_q[3] && !prev_q[3] |=> counter_reset_q;
   endproperty
   a_mode_rst: assert property (p_mode_rst) else $error("mode 0 reset missed");
   property p_mode1_dis;
      @(posedge clk_sys) disable iff (!rst_n_q)
      mode_q == scio_pkg::SCIO_MODE_DIS3 && sync2_q[2] |=> count_inhibit_q;
   endproperty
   a_mode1_dis: assert property (p_mode1_dis) else $error("mode 1 disable missed");
   property p_mode2_dis;
      @(posedge clk_sys) disable iff (!rst_n_q)
      mode_q == scio_pkg::SCIO_MODE_DIS4 && sync2_q[3] |=> count_inhibit_q && count_pulse_q == 32'h0000_0000;
   endproperty
   a_mode2_dis: assert property (p_mode2_dis) else $error("mode 2 disable missed");
   property p_mode3;
      @(posedge clk_sys) disable iff (!rst_n_q)
      mode_q == scio_pkg::SCIO_MODE_TEST |=> !count_inhibit_q && !counter_reset_q && !next_pulse_q &&
         ext_test_q == $past(sync2_q[3]);
   endproperty
   a_mode3: assert property (p_mode3) else $error("mode 3 routing wrong");
   property p_led_init;
      @(posedge clk_sys) disable iff (!rst_n_q)
      !init_done_q && $past(rst_n_q) |=> led_q == (scio_pkg::LED_ALL & ~scio_pkg::LED_READY);
   endproperty
   a_led_init: assert property (p_led_init) else $error("init indicators wrong");
   property p_ctrl_set;
      @(posedge clk_sys) disable iff (!rst_n_q)
      reg_wr && reg_addr == scio_pkg::CTRL_OFS && reg_wdata[scio_pkg::TEST_BIT] &&
         !reg_wdata[scio_pkg::TEST_BIT + scio_pkg::CLR_SHIFT] |=> test_q;
   endproperty
   a_ctrl_set: assert property (p_ctrl_set) else $error("test mode not set");
endmodule // scio_top

//--- core/scio_pkg.sv
package scio_pkg;
   // Register offsets (byte addresses)
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam logic [11:0] KEY_PULSE_OFS = 12'h068;
   localparam logic [11:0] FIFO_LO_OFS = 12'h100;
   localparam logic [11:0] FIFO_HI_OFS = 12'h1fc;
   localparam logic [11:0] FIFO_RD_OFS = 12'h200;
   // Status register fields
   localparam int STAT_LINES_LSB = 0;
   localparam int STAT_USER_LSB = 4;
   localparam int STAT_INIT_BIT = 6;
   // Control set bits (low half) and clear bits (high half, +8)
   localparam int MODE0_BIT = 2;
   localparam int MODE1_BIT = 3;
   localparam int TEST_BIT = 4;
   localparam int PULSER_BIT = 5;
   localparam int FTEST_BIT = 1;
   localparam int CLR_SHIFT = 8;
   localparam int FTEST_CLR_BIT = 9;
   // Address modifier codes
   localparam logic [5:0] AM_A24_SUP_BLT = 6'h3f;
   localparam logic [5:0] AM_A24_SUP_DAT = 6'h3d;
   localparam logic [5:0] AM_A24_NP_BLT = 6'h3b;
   localparam logic [5:0] AM_A24_NP_DAT = 6'h39;
   localparam logic [5:0] AM_A16_SUP = 6'h2d;
   localparam logic [5:0] AM_A16_NP = 6'h29;
   localparam logic [5:0] AM_A32_SUP_BLT = 6'h0f;
   localparam logic [5:0] AM_A32_SUP_DAT = 6'h0d;
   localparam logic [5:0] AM_A32_NP_BLT = 6'h0b;
   localparam logic [5:0] AM_A32_NP_DAT = 6'h09;
   // Low modifier bits shared by every block transfer code
   localparam logic [1:0] AM_BLT_LOW = 2'b11;
   // Timing
   localparam int CLK_NS = 10;
   localparam int PULSER_PERIOD_NS = 40;
   localparam int PULSER_DIV = PULSER_PERIOD_NS / CLK_NS;
   localparam logic [1:0] PULSER_LAST = 2'(PULSER_DIV - 1);
   localparam int INIT_NS = 1000;
   localparam logic [7:0] INIT_LAST = 8'((INIT_NS / CLK_NS) - 1);
   localparam logic [7:0] LED_ALL = 8'hff;
   localparam logic [7:0] LED_READY = 8'h01;
   localparam logic [7:0] LED_POWER = 8'h02;
   localparam logic [3:0] FIFO_AW = 4'h6;
   typedef enum logic [1:0] {
      SCIO_MODE_USER = 2'b00,
      SCIO_MODE_DIS3 = 2'b01,
      SCIO_MODE_DIS4 = 2'b10,
      SCIO_MODE_TEST = 2'b11
   } scio_mode_e;
endpackage

//--- test/scio_panel.sv
`timescale 1ns/1ps
// ----
// Front-panel experiment model
// ----
module scio_panel (
   // Clock
   input wire logic clk_sys,
   // Control inputs 1..4 towards the scaler
   output logic [3:0] ctl_in
);
   initial begin
      ctl_in = 4'h0;
   end
   // Next pulse, user bits set up a cycle ahead and held past the edge
   task automatic next_pulse(input logic [1:0] ub);
      @(posedge clk_sys);
      ctl_in[2:1] <= ub;
      @(posedge clk_sys);
      ctl_in[0] <= 1'b1;
      repeat (2) @(posedge clk_sys);
      ctl_in[0] <= 1'b0;
      repeat (2) @(posedge clk_sys);
      // Hold over: the lines no longer carry the latched value
      ctl_in[2:1] <= ~ub;
   endtask
   // Level input; a disable stays up for the whole inhibit window
   task automatic set_level(input int idx, input logic v);
      @(posedge clk_sys);
      ctl_in[idx] <= v;
   endtask
endmodule // scio_panel

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [5:0] bus_am = 6'h00;
   logic en_a16 = 1'b0, en_a24 = 1'b0, en_a32 = 1'b0;
   logic copy_busy = 1'b0, deadtime_en = 1'b0, ch0_deadtimed = 1'b0;
   logic fifo_almost_full = 1'b0, fifo_full = 1'b0;
   logic [31:0] fp_count = 32'h0;
   logic [31:0] reg_rdata_q, count_pulse_q;
   logic [3:0] ctl_in, ctl_out_q;
   logic am_accept_q, block_transfer_cycle_q, count_inhibit_q;
   logic next_pulse_q, counter_reset_q, ext_test_q;
   logic [1:0] user_bits_q;
   logic [7:0] led_q;
   int error_cnt = 0;
   int checks = 0;
   int n_next = 0, n_rst = 0, n_ones = 0;
   logic [31:0] seed = 32'd62;

   always #5 clk_sys = ~clk_sys;

   scio_panel panel (.clk_sys, .ctl_in);
   scio_top uut (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_q, .bus_am, .en_a16, .en_a24, .en_a32, .am_accept_q,
      .block_transfer_cycle_q, .ctl_in, .copy_busy, .deadtime_en,
      .ch0_deadtimed, .fifo_almost_full, .fifo_full, .ctl_out_q, .fp_count,
      .count_pulse_q, .count_inhibit_q, .next_pulse_q, .user_bits_q,
      .counter_reset_q, .ext_test_q, .led_q);

   // Pulse counters, so one-cycle outputs are never missed
   always @(posedge clk_sys) begin
      if (next_pulse_q === 1'b1) n_next++;
      if (counter_reset_q === 1'b1) n_rst++;
      if (count_pulse_q === 32'hffffffff) n_ones++;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Accepted modifier codes per enabled address space
   function automatic logic am_ok(input logic [5:0] am, input logic [2:0] en);
      case (am)
         6'h3f, 6'h3b, 6'h3d, 6'h39: return en[1];
         6'h2d, 6'h29: return en[0];
         6'h0f, 6'h0b, 6'h0d, 6'h09: return en[2];
         default: return 1'b0;
      endcase
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_q;
   endtask

   // Hang guard: the whole run needs well under 10000 cycles
   initial begin
      #300000;
      error_cnt++;
      $display("watchdog expired");
      complete_run();
   end

   initial begin
      logic [31:0] d, fp;
      logic [31:0] fw [4];
      logic [11:0] fa [4];
      logic [1:0] ub;
      logic a;
      fa = '{12'h100, 12'h104, 12'h180, 12'h1fc};
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      tick(3);
      chk(led_q, 32'hfe);
      rd(12'h000, d);
      chk(d, 32'h0);
      tick(110);
      chk(led_q, 32'h03);
      $display("test reset done");
      // Every input mode; user bits, disable and reset routing
      for (int m = 0; m < 4; m++) begin
         wr(12'h000, 32'h0c00);
         wr(12'h000, 32'(m) << 2);
         rd(12'h000, d);
         chk(d[3:2], m);
         ub = 2'(xs());
         n_next = 0;
         panel.next_pulse(ub);
         tick(4);
         chk(n_next, m != 3);
         if (m != 3) chk(user_bits_q, m == 1 ? {1'b0, ub[0]} : ub);
         n_rst = 0;
         fp = xs() | 32'h1;
         @(posedge clk_sys);
         fp_count <= fp;
         panel.set_level(2, 1'b1);
         panel.set_level(3, 1'b1);
         tick(5);
         chk(n_rst, m < 2);
         chk(count_inhibit_q, m == 1 || m == 2);
         chk(ext_test_q, m == 3);
         if (m < 3) chk(count_pulse_q, m == 0 ? fp : 32'h0);
         panel.set_level(2, 1'b0);
         panel.set_level(3, 1'b0);
         tick(5);
         if (m < 3) chk(count_pulse_q, fp);
      end
      wr(12'h000, 32'h0c00);
      // Known user bits, so the status read below has a fixed expectation
      panel.next_pulse(2'b10);
      tick(4);
      chk(user_bits_q, 2'b10);
      $display("test modes done");
      // Status lines towards control outputs 5..8
      for (int i = 0; i < 16; i++) begin
         d = xs();
         @(posedge clk_sys);
         {fifo_full, fifo_almost_full, ch0_deadtimed, deadtime_en, copy_busy} <= d[4:0];
         rd(12'h004, fp);
         chk(ctl_out_q, {d[4], d[3], d[2] & d[1], d[0]});
         chk(fp[6:0], {3'b110, d[4], d[3], d[2] & d[1], d[0]});
      end
      $display("test outputs done");
      // All modifier codes under all enable combinations
      for (int i = 0; i < 512; i++) begin
         @(posedge clk_sys);
         bus_am <= i[5:0];
         {en_a32, en_a24, en_a16} <= i[8:6];
         tick(2);
         a = am_ok(i[5:0], i[8:6]);
         chk(am_accept_q, a);
         chk(block_transfer_cycle_q, a && i[1:0] == 2'b11);
      end
      $display("test modifiers done");
      // Key pulse refused without test mode, single pulse with it
      n_ones = 0;
      wr(12'h068, xs());
      tick(6);
      chk(n_ones, 0);
      wr(12'h000, 32'h10);
      tick(4);
      chk(count_pulse_q, 32'h0);
      n_ones = 0;
      wr(12'h068, xs());
      tick(6);
      chk(n_ones, 1);
      wr(12'h000, 32'h20);
      tick(2);
      n_ones = 0;
      tick(40);
      chk(n_ones, 10);
      wr(12'h000, 32'h3000);
      rd(12'h000, d);
      chk(d, 32'h0);
      $display("test pulser done");
      // FIFO test window, clear bit wins over set bit
      wr(12'h000, 32'h2);
      rd(12'h000, d);
      chk(d[1], 1'b1);
      for (int i = 0; i < 4; i++) begin
         fw[i] = xs();
         wr(fa[i], fw[i]);
      end
      for (int i = 0; i < 5; i++) begin
         rd(12'h200, d);
         chk(d, i < 4 ? fw[i] : 32'h0);
      end
      wr(12'h000, 32'h202);
      rd(12'h000, d);
      chk(d[1], 1'b0);
      wr(12'h100, xs());
      rd(12'h200, d);
      chk(d, 32'h0);
      rd(12'h300, d);
      chk(d, 32'h0);
      $display("test fifo done");
      complete_run();
   end
endmodule // tb
